// ### rtl/coil_driver_mode_control.sv
// Operating-mode controller of a coil lens driver with its register file.
// Assumes the serial clock and data, and the three fault lines, arrive as
// pins asynchronous to ref_clk; the link logic runs on the serial clock.
`default_nettype none
module coil_driver_mode_control #(
    parameter int unsigned LOW_CYC  = coil_mode_pkg::LOW_CYC,
    parameter logic [6:0]  DEV_ADDR = coil_mode_pkg::DEV_ADDR_DEF
) (
    input  wire logic                        ref_clk,
    input  wire logic                        rstn,
    input  wire logic                        scl_i,
    input  wire logic                        sda_i,
    output logic                             sda_o,
    output logic                             sda_oe,
    input  wire logic                        overtemp_fault,
    input  wire logic                        coil_short_fault,
    input  wire logic                        coil_open_fault,
    output logic                             stage_en,
    output logic [coil_mode_pkg::CUR_W-1:0]  coil_current_setting,
    output logic [7:0]                       resonance_freq_code,
    output logic                             ring_en,
    output logic [7:0]                       drive_mode,
    output logic [2:0]                       op_state,
    output logic [coil_mode_pkg::FLT_N-1:0]  fault_status
);
    import coil_mode_pkg::*;

    localparam int LW = $clog2(LOW_CYC + 1);
    localparam logic [LW-1:0] LOW_END = LW'(LOW_CYC);

    // Whole state of the core domain.
    typedef struct packed {
        logic             scl_m;
        logic             scl_s;
        logic [FLT_N-1:0] flt_m;
        logic [FLT_N-1:0] flt_s;
        logic             wt_m;
        logic             wt_s;
        logic             wt_d;
        logic [LW-1:0]    lowcnt;
        op_state_e        st;
        logic             ring;
        logic [CUR_W-1:0] cur;
        logic [7:0]       mode;
        logic [7:0]       freq;
        logic [FLT_N-1:0] status;
        logic             stage;
    } core_s;

    core_s            r_r;
    core_s            r_nxt;
    logic [7:0]       rd_ptr;
    logic [7:0]       rd_data;
    logic             wr_tgl;
    logic [7:0]       wr_addr;
    logic [7:0]       wr_data;
    logic [FLT_N-1:0] flt_pins;
    logic             wr_ev;
    logic             low_long;
    logic             srst;
    logic             cur_wr;
    logic             load_def;
    logic             flt_any;

    // The link runs on the serial clock and hands each written byte over
    // as a toggle, with address and data held steady for a whole byte time.
    serial_reg_link #(
        .DEV_ADDR (DEV_ADDR)
    ) u_link (
        .scl      (scl_i),
        .sda_i    (sda_i),
        .rstn     (rstn),
        .rd_data  (rd_data),
        .rd_ptr   (rd_ptr),
        .wr_tgl   (wr_tgl),
        .wr_addr  (wr_addr),
        .wr_data  (wr_data),
        .sda_o    (sda_o),
        .sda_oe   (sda_oe)
    );

    // Fault pins gathered in status bit order.
    assign flt_pins[FLT_OT_BIT] = overtemp_fault;
    assign flt_pins[FLT_SH_BIT] = coil_short_fault;
    assign flt_pins[FLT_OP_BIT] = coil_open_fault;

    // Read view of the register file; the pointer comes from the link and
    // only moves between bytes, so the selected value is settled when read.
    always_comb begin
        rd_data = 8'h00;
        case (rd_ptr)
            REG_CONTROL: rd_data[CTRL_RING_BIT] = r_r.ring;
            REG_CUR_HI:  rd_data[CUR_W-9:0] = r_r.cur[CUR_W-1:8];
            REG_CUR_LO:  rd_data = r_r.cur[7:0];
            REG_STATUS:  rd_data[FLT_N-1:0] = r_r.status;
            REG_MODE:    rd_data = r_r.mode;
            REG_FREQ:    rd_data = r_r.freq;
            default:     rd_data = 8'h00;
        endcase
    end

    // Next state of the core domain.
    always_comb begin
        r_nxt = r_r;

        // Pins and the write toggle pass two flip-flops before use.
        r_nxt.scl_m = scl_i;
        r_nxt.scl_s = r_r.scl_m;
        r_nxt.flt_m = flt_pins;
        r_nxt.flt_s = r_r.flt_m;
        r_nxt.wt_m  = wr_tgl;
        r_nxt.wt_s  = r_r.wt_m;
        r_nxt.wt_d  = r_r.wt_s;

        flt_any  = |r_r.flt_s;
        wr_ev    = (r_r.wt_s != r_r.wt_d);
        srst     = 1'b0;
        cur_wr   = 1'b0;
        load_def = 1'b0;

        // Low-time counter saturates so a long low never wraps back to zero.
        if (r_r.scl_s)
            r_nxt.lowcnt = '0;
        else if (r_r.lowcnt != LOW_END)
            r_nxt.lowcnt = r_r.lowcnt + 1'b1;
        low_long = (r_r.lowcnt == LOW_END);

        // Faults are sticky; a new fault always wins over any clear below.
        r_nxt.status = r_r.status | r_r.flt_s;

        case (r_r.st)
            ST_LOWPWR: begin
                // Writes are dropped here; the line is low anyway.
                if (r_r.scl_s) begin
                    r_nxt.st = ST_IDLE;
                    load_def = 1'b1;
                end else begin
                    r_nxt.st = ST_LOWPWR;
                end
            end
            ST_IDLE, ST_DRIVE: begin
                if (low_long) begin
                    r_nxt.st = ST_LOWPWR;
                end else begin
                    // Register writes from the link.
                    if (wr_ev) begin
                        case (wr_addr)
                            REG_CONTROL: begin
                                r_nxt.ring = wr_data[CTRL_RING_BIT];
                                srst = wr_data[CTRL_SRST_BIT];
                            end
                            REG_CUR_HI: begin
                                r_nxt.cur[CUR_W-1:8] = wr_data[CUR_W-9:0];
                                cur_wr = 1'b1;
                            end
                            REG_CUR_LO: begin
                                r_nxt.cur[7:0] = wr_data;
                                cur_wr = 1'b1;
                            end
                            REG_MODE: r_nxt.mode = wr_data;
                            REG_FREQ: r_nxt.freq = wr_data;
                            default: r_nxt.mode = r_r.mode;
                        endcase
                    end

                    // Soft reset outranks a fault, a fault in the drive state outranks a write.
                    if (srst) begin
                        r_nxt.st = ST_IDLE;
                        load_def = 1'b1;
                    end else if (r_r.st == ST_DRIVE && flt_any) begin
                        r_nxt.st  = ST_IDLE;
                        r_nxt.cur = '0;
                    end else if (r_nxt.cur == '0) begin
                        r_nxt.st = ST_IDLE;
                    end else if (r_r.st == ST_IDLE && cur_wr) begin
                        r_nxt.st     = ST_DRIVE;
                        r_nxt.status = r_r.flt_s;
                    end
                end
            end
            default: begin
                r_nxt.st = ST_IDLE;
                load_def = 1'b1;
            end
        endcase

        // Defaults; the status keeps any fault that is present right now.
        if (load_def) begin
            r_nxt.ring   = RING_RESET;
            r_nxt.cur    = CUR_RESET;
            r_nxt.mode   = MODE_RESET;
            r_nxt.freq   = FREQ_RESET;
            r_nxt.status = r_r.flt_s;
        end

        // The output stage follows the state one for one.
        r_nxt.stage = (r_nxt.st == ST_DRIVE);
    end

    // Register the core state.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            r_r.scl_m  <= 1'b1;
            r_r.scl_s  <= 1'b1;
            r_r.flt_m  <= '0;
            r_r.flt_s  <= '0;
            r_r.wt_m   <= 1'b0;
            r_r.wt_s   <= 1'b0;
            r_r.wt_d   <= 1'b0;
            r_r.lowcnt <= '0;
            r_r.st     <= ST_IDLE;
            r_r.ring   <= RING_RESET;
            r_r.cur    <= CUR_RESET;
            r_r.mode   <= MODE_RESET;
            r_r.freq   <= FREQ_RESET;
            r_r.status <= '0;
            r_r.stage  <= 1'b0;
        end else begin
            r_r <= r_nxt;
        end
    end

    // Outputs come straight from the state flip-flops.
    assign stage_en             = r_r.stage;
    assign coil_current_setting = r_r.cur;
    assign resonance_freq_code  = r_r.freq;
    assign ring_en              = r_r.ring;
    assign drive_mode           = r_r.mode;
    assign op_state             = r_r.st;
    assign fault_status         = r_r.status;

endmodule
`default_nettype wire

// ### rtl/coil_mode_pkg.sv
// Shared constants for the coil driver mode controller: register offsets,
// field positions, reset values, timing counts and the operating states.
// Assumes a 200 MHz core clock; the serial link runs on its own clock.
`default_nettype none
package coil_mode_pkg;

    // Register byte offsets on the serial link.
    localparam logic [7:0] REG_CONTROL = 8'h02;
    localparam logic [7:0] REG_CUR_HI  = 8'h03;
    localparam logic [7:0] REG_CUR_LO  = 8'h04;
    localparam logic [7:0] REG_STATUS  = 8'h05;
    localparam logic [7:0] REG_MODE    = 8'h06;
    localparam logic [7:0] REG_FREQ    = 8'h07;

    // Field positions.
    localparam int CTRL_SRST_BIT = 0;
    localparam int CTRL_RING_BIT = 1;
    localparam int CUR_W         = 10;
    localparam int FLT_OT_BIT    = 0;
    localparam int FLT_SH_BIT    = 1;
    localparam int FLT_OP_BIT    = 2;
    localparam int FLT_N         = 3;

    // Reset values.
    localparam logic             RING_RESET = 1'b1;
    localparam logic [CUR_W-1:0] CUR_RESET  = 10'h000;
    localparam logic [7:0]       MODE_RESET = 8'h00;
    localparam logic [7:0]       FREQ_RESET = 8'h83;

    // Timing: serial clock low time that forces the lowest-power state.
    localparam int CLK_PERIOD_NS = 5;
    localparam int LOW_TIME_NS   = 500000;
    localparam int LOW_CYC       = (LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Link framing: bit slot that carries the acknowledge, and the last data bit slot.
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_LAST = 4'h7;

    // Link address; the value is arbitrary.
    localparam logic [6:0] DEV_ADDR_DEF = 7'h2A;

    // Operating states.
    typedef enum logic [2:0] {
        ST_LOWPWR = 3'b001,
        ST_IDLE   = 3'b010,
        ST_DRIVE  = 3'b100
    } op_state_e;

endpackage
`default_nettype wire

// ### rtl/serial_reg_link.sv
// Serial register link slave: address match, register pointer with
// auto-increment, byte writes out as a toggle event, byte reads in.
// Assumes the serial clock is the clock of this logic and the read data
// input is steady while the link shifts a byte out.
`default_nettype none
module serial_reg_link #(
    parameter logic [6:0] DEV_ADDR = coil_mode_pkg::DEV_ADDR_DEF
) (
    input  wire logic       scl,
    input  wire logic       sda_i,
    input  wire logic       rstn,
    input  wire logic [7:0] rd_data,
    output logic [7:0]      rd_ptr,
    output logic            wr_tgl,
    output logic [7:0]      wr_addr,
    output logic [7:0]      wr_data,
    output logic            sda_o,
    output logic            sda_oe
);
    import coil_mode_pkg::*;

    typedef enum logic [4:0] {
        PH_IGNORE = 5'b00001,
        PH_ADDR   = 5'b00010,
        PH_REG    = 5'b00100,
        PH_WR     = 5'b01000,
        PH_RD     = 5'b10000
    } link_ph_e;

    typedef struct packed {
        link_ph_e   ph;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] tx;
        logic [7:0] ptr;
        logic       ack;
        logic       st_seen;
        logic       wt;
        logic [7:0] wa;
        logic [7:0] wd;
    } link_s;

    link_s      r_r;
    link_s      r_nxt;
    logic       start_tgl_r;
    logic [7:0] byte_in;

    // A start is a falling data line while the clock is high; it flips a toggle.
    always_ff @(negedge sda_i or negedge rstn) begin
        if (!rstn)
            start_tgl_r <= 1'b0;
        else if (scl)
            start_tgl_r <= ~start_tgl_r;
    end

    // Bit sampling on the rising clock edge.
    always_comb begin
        r_nxt   = r_r;
        byte_in = {r_r.sh[6:0], sda_i};
        if (start_tgl_r != r_r.st_seen) begin
            r_nxt.st_seen = start_tgl_r;
            r_nxt.ph      = PH_ADDR;
            r_nxt.cnt     = 4'h1;
            r_nxt.sh      = byte_in;
            r_nxt.ack     = 1'b0;
        end else if (r_r.cnt == BIT_ACK) begin
            r_nxt.cnt = 4'h0;
            r_nxt.ack = 1'b0;
            if (r_r.ph == PH_RD) begin
                r_nxt.tx = rd_data;
                if (sda_i)
                    r_nxt.ph = PH_IGNORE;
            end
        end else begin
            r_nxt.cnt = r_r.cnt + 4'h1;
            r_nxt.sh  = byte_in;
            if (r_r.cnt == BIT_LAST) begin
                case (r_r.ph)
                    PH_ADDR: begin
                        r_nxt.ack = (byte_in[7:1] == DEV_ADDR);
                        if (byte_in[7:1] != DEV_ADDR)
                            r_nxt.ph = PH_IGNORE;
                        else
                            r_nxt.ph = byte_in[0] ? PH_RD : PH_REG;
                    end
                    PH_REG: begin
                        r_nxt.ptr = byte_in;
                        r_nxt.ack = 1'b1;
                        r_nxt.ph  = PH_WR;
                    end
                    PH_WR: begin
                        r_nxt.wa  = r_r.ptr;
                        r_nxt.wd  = byte_in;
                        r_nxt.wt  = ~r_r.wt;
                        r_nxt.ptr = r_r.ptr + 8'h01;
                        r_nxt.ack = 1'b1;
                    end
                    PH_RD: begin
                        r_nxt.ptr = r_r.ptr + 8'h01;
                        r_nxt.ack = 1'b0;
                    end
                    default: r_nxt.ack = 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge scl or negedge rstn) begin
        if (!rstn)
            r_r <= '{ph: PH_IGNORE, default: '0};
        else
            r_r <= r_nxt;
    end

    // Data line drive changes on the falling edge, while the clock is low.
    always_ff @(negedge scl or negedge rstn) begin
        if (!rstn) begin
            sda_oe <= 1'b0;
            sda_o  <= 1'b0;
        end else begin
            sda_o <= 1'b0;
            if (r_r.cnt == BIT_ACK)
                sda_oe <= r_r.ack;
            else if (r_r.ph == PH_RD)
                sda_oe <= ~r_r.tx[~r_r.cnt[2:0]];
            else
                sda_oe <= 1'b0;
        end
    end

    assign rd_ptr  = r_r.ptr;
    assign wr_tgl  = r_r.wt;
    assign wr_addr = r_r.wa;
    assign wr_data = r_r.wd;

endmodule
`default_nettype wire

// ### verif/coil_mode_chk.sv
// Checker for the coil mode controller, watching its top-level ports only.
// Assumes one core clock ref_clk and an asynchronous active-low rstn.
`default_nettype none
module coil_mode_chk
    import coil_mode_pkg::*;
#(
    parameter int unsigned LOW_CYC = coil_mode_pkg::LOW_CYC
) (
    input wire logic                            ref_clk,
    input wire logic                            rstn,
    input wire logic                            scl_i,
    input wire logic                            overtemp_fault,
    input wire logic                            coil_short_fault,
    input wire logic                            coil_open_fault,
    input wire logic                            stage_en,
    input wire logic [coil_mode_pkg::CUR_W-1:0] coil_current_setting,
    input wire logic [7:0]                      resonance_freq_code,
    input wire logic                            ring_en,
    input wire logic [7:0]                      drive_mode,
    input wire logic [2:0]                      op_state,
    input wire logic [coil_mode_pkg::FLT_N-1:0] fault_status
);
    timeunit 1ns;
    timeprecision 100ps;
    logic        flt;
    logic [31:0] low_cnt_r;

    // Any fault pin; faults are treated as levels.
    assign flt = overtemp_fault | coil_short_fault | coil_open_fault;

    // Length of the present low stretch on the raw clock pin, saturating.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            low_cnt_r <= '0;
        end else if (scl_i) begin
            low_cnt_r <= '0;
        end else if (low_cnt_r != '1) begin
            low_cnt_r <= low_cnt_r + 32'h1;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    // State and stage enable must agree in every cycle; state and current setting outside the lowest-power state.
    stage_drive_a: assert property (stage_en == (op_state == ST_DRIVE))
        else $error("stage enable differs from drive state");
    cur_drive_a: assert property (op_state != ST_LOWPWR |->
        (op_state == ST_DRIVE) == (coil_current_setting != '0))
        else $error("drive state does not match current setting");
    // Faults, allowing two synchroniser stages and one register stage.
    fault_leave_a: assert property (flt [*4] |-> op_state != ST_DRIVE)
        else $error("drive state kept under a fault");
    fault_cur_a: assert property (flt [*4] |-> coil_current_setting == '0)
        else $error("current setting kept under a fault");
    drive_stat_a: assert property ($rose(op_state == ST_DRIVE) && !flt |->
        fault_status == '0)
        else $error("status not cleared on drive entry");
    // Low time on the clock pin; the synchroniser adds a few cycles.
    low_enter_a: assert property (low_cnt_r > LOW_CYC + 6 |-> op_state == ST_LOWPWR)
        else $error("lowest power not entered after long low time");
    low_early_a: assert property ($rose(op_state == ST_LOWPWR) |-> low_cnt_r >= LOW_CYC)
        else $error("lowest power entered too early");
    low_hold_a: assert property ((!scl_i) [*4] ##0 op_state == ST_LOWPWR |=>
        op_state == ST_LOWPWR)
        else $error("lowest power left while clock low");
    wake_idle_a: assert property ((op_state == ST_LOWPWR && scl_i) ##1 scl_i [*5] |->
        op_state == ST_IDLE)
        else $error("no idle after clock rise");
    wake_dflt_a: assert property ($fell(op_state == ST_LOWPWR) |->
        resonance_freq_code == FREQ_RESET && ring_en == RING_RESET &&
        drive_mode == MODE_RESET && coil_current_setting == CUR_RESET)
        else $error("defaults not loaded on wake");
endmodule
bind coil_driver_mode_control coil_mode_chk #(.LOW_CYC(LOW_CYC)) coil_mode_chk_i (.*);
`default_nettype wire

// ### verif/host_master.sv
// Behavioural serial bus master standing in for the host processor.
// Assumes the bench resolves the open-drain data line with a pull-up.
`default_nettype none
module host_master #(
    parameter logic [6:0] ADDR = 7'h2A
) (
    output logic     scl,
    output logic     sda_pull,
    input wire logic sda_line
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int Q = 8;

    // The clock stands high between frames and data is released.
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // Data changes only while the clock is low; sampling mid high phase.
    task automatic bit_io(input logic b, output logic s);
        sda_pull = !b;
        #Q scl = 1'b1;
        #Q s = sda_line;
        #Q scl = 1'b0;
        #Q;
    endtask

    // Start or repeated start: data falls while the clock is high.
    task automatic start();
        sda_pull = 1'b0;
        #Q scl = 1'b1;
        #Q sda_pull = 1'b1;
        #Q scl = 1'b0;
        #Q;
    endtask

    task automatic stop();
        sda_pull = 1'b1;
        #Q scl = 1'b1;
        #Q sda_pull = 1'b0;
        #(2*Q);
    endtask

    // Eight bits out, most significant first, then a released ack slot.
    task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
            q[i] = s;
        end
        bit_io(1'b1, s);
        ack = !s;
    endtask

    // Whole bytes only; the code table choice is the caller's.
    task automatic write_reg(input logic [7:0] r, input logic [7:0] d, output logic [2:0] a);
        logic [7:0] q;
        start();
        byte_io({ADDR, 1'b0}, q, a[2]);
        byte_io(r, q, a[1]);
        byte_io(d, q, a[0]);
        stop();
    endtask

    // Defined-location read; the master answers the data byte with a nack.
    task automatic read_reg(input logic [7:0] r, output logic [7:0] d, output logic [2:0] a);
        logic n;
        start();
        byte_io({ADDR, 1'b0}, d, a[2]);
        byte_io(r, d, a[1]);
        start();
        byte_io({ADDR, 1'b1}, d, a[0]);
        byte_io(8'hFF, d, n);
        stop();
    endtask

    // Holds the clock low for a chosen time, then leaves it high a while.
    task automatic hold_low(input int ns);
        scl = 1'b0;
        #(ns);
        scl = 1'b1;
        #(2*Q);
    endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the coil mode controller and its serial host.
// Assumes the host model makes the link clock; the bench makes ref_clk.
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top import coil_mode_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int LC = 50;
    logic             ref_clk = 1'b0;
    logic             rstn = 1'b1;
    logic [2:0]       flt = 3'b000;
    logic             scl;
    logic             sda_pull;
    logic             sda_line;
    logic             sda_o;
    logic             sda_oe;
    logic             stage_en;
    logic             ring_en;
    logic [CUR_W-1:0] cur;
    logic [7:0]       freq;
    logic [7:0]       mode;
    logic [2:0]       st;
    logic [FLT_N-1:0] fs;
    logic [7:0]       rd_v;
    int               failures = 0;
    int               cmp_count = 0;

    // Core clock, 200 MHz.
    always #2.5 ref_clk = ~ref_clk;

    // Open-drain data wire with a pull-up.
    assign sda_line = !(sda_pull || (sda_oe && !sda_o));

    coil_driver_mode_control #(.LOW_CYC(LC)) coil_driver_mode_control_i (
        .ref_clk(ref_clk), .rstn(rstn), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe(sda_oe), .overtemp_fault(flt[0]), .coil_short_fault(flt[1]),
        .coil_open_fault(flt[2]), .stage_en(stage_en), .coil_current_setting(cur),
        .resonance_freq_code(freq), .ring_en(ring_en), .drive_mode(mode),
        .op_state(st), .fault_status(fs));

    host_master host_master_i (.scl(scl), .sda_pull(sda_pull), .sda_line(sda_line));

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Lets the crossing land, then leaves the sampling edge.
    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    task automatic wait_state(input logic [2:0] s);
        int n;
        n = 0;
        while (st !== s && n < 400) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (st !== s) begin
            failures++;
            $display("ERROR t=%0t state=%0h exp=%0h", $time, st, s);
            tally_and_finish();
        end
    endtask

    task automatic wr(input logic [7:0] r, input logic [7:0] d);
        logic [2:0] a;
        host_master_i.write_reg(r, d, a);
        `CHK(a, 3'b111)
        settle();
    endtask

    task automatic rd(input logic [7:0] r, output logic [7:0] d);
        logic [2:0] a;
        host_master_i.read_reg(r, d, a);
        `CHK(a, 3'b111)
    endtask

    task automatic t_defaults();
        `CHK({st, stage_en, cur, ring_en, mode, fs}, {ST_IDLE, 1'b0, CUR_RESET, RING_RESET, MODE_RESET, 3'b000})
        rd(REG_FREQ, rd_v);
        `CHK(rd_v, FREQ_RESET)
        rd(REG_CONTROL, rd_v);
        `CHK(rd_v, 8'h02)
        $display("defaults test done");
    endtask

    // Codes for 50, 100, 145 or 146, and 150 Hz.
    task automatic t_freq();
        logic [7:0] codes [4] = '{8'h00, 8'hBF, 8'hFB, 8'hFF};
        foreach (codes[i]) begin
            wr(REG_FREQ, codes[i]);
            rd(REG_FREQ, rd_v);
            `CHK({freq, rd_v}, {codes[i], codes[i]})
        end
        wr(8'h01, 8'h5A);
        rd(8'h01, rd_v);
        `CHK(rd_v, 8'h00)
        wr(REG_STATUS, 8'h07);
        `CHK(fs, 3'b000)
        $display("frequency test done");
    endtask

    // Only the low two bits of the high byte belong to the setting.
    task automatic t_drive();
        wr(REG_MODE, 8'hA5);
        wr(REG_CUR_HI, 8'hFF);
        `CHK({st, stage_en, cur, mode}, {ST_DRIVE, 1'b1, 10'h300, 8'hA5})
        wr(REG_CUR_LO, 8'hFF);
        `CHK(cur, 10'h3FF)
        wr(REG_CUR_HI, 8'h00);
        wr(REG_CUR_LO, 8'h00);
        `CHK({st, stage_en}, {ST_IDLE, 1'b0})
        $display("drive test done");
    endtask

    task automatic t_fault();
        for (int i = 0; i < FLT_N; i++) begin
            wr(REG_CUR_LO, 8'h40);
            `CHK(st, ST_DRIVE)
            flt = 3'b001 << i;
            wait_state(ST_IDLE);
            `CHK({cur, fs}, {10'h000, 3'b001 << i})
            @(posedge ref_clk);
            #1 flt = 3'b000;
            repeat (20) @(posedge ref_clk);
            #1 `CHK(st, ST_IDLE)
            wr(REG_CUR_LO, 8'h40);
            `CHK({st, fs}, {ST_DRIVE, 3'b000})
            wr(REG_CUR_LO, 8'h00);
        end
        $display("fault test done");
    endtask

    task automatic t_soft();
        wr(REG_FREQ, 8'h10);
        wr(REG_CONTROL, 8'h00);
        wr(REG_CUR_LO, 8'h11);
        `CHK({st, ring_en}, {ST_DRIVE, 1'b0})
        wr(REG_CONTROL, 8'h01);
        `CHK({st, cur, freq, ring_en}, {ST_IDLE, CUR_RESET, FREQ_RESET, RING_RESET})
        rd(REG_CONTROL, rd_v);
        `CHK(rd_v, 8'h02)
        $display("soft reset test done");
    endtask

    // Two short lows in a row must not add up to the long one.
    task automatic t_lowpwr();
        wr(REG_MODE, 8'h3C);
        wr(REG_CUR_LO, 8'h22);
        host_master_i.hold_low((LC - 10) * 5);
        host_master_i.hold_low((LC - 10) * 5);
        `CHK(st, ST_DRIVE)
        fork
            host_master_i.hold_low((LC + 30) * 5);
            begin
                repeat (LC + 10) @(posedge ref_clk);
                #1 `CHK({st, stage_en}, {ST_LOWPWR, 1'b0})
                repeat (10) @(posedge ref_clk);
                #1 `CHK(st, ST_LOWPWR)
            end
        join
        wait_state(ST_IDLE);
        `CHK({cur, mode, freq}, {CUR_RESET, MODE_RESET, FREQ_RESET})
        $display("low power test done");
    endtask

    // Reset, then each scenario in turn.
    // Reset falls after time zero so that the link flops, which see no clock
    // edge during reset, still get the falling edge their reset waits for.
    initial begin
        #1 rstn = 1'b0;
        repeat (20) @(posedge ref_clk);
        #1 rstn = 1'b1;
        settle();
        t_defaults();
        t_freq();
        t_drive();
        t_fault();
        t_soft();
        t_lowpwr();
        tally_and_finish();
    end
endmodule
`default_nettype wire
